/* File: include/acmsr_pkg.sv */
package acmsr_pkg;
  localparam int RES_W   = 24;
  localparam int STAT_W  = 8;
  localparam int FRAME_W = 40;
  localparam int CMD_W   = 8;
  localparam int GPIO_W  = 4;

  // Register offsets
  localparam logic [6:0] ADDR_RESULT   = 7'h2C;
  localparam logic [6:0] ADDR_IF_FMT   = 7'h14;
  localparam logic [6:0] ADDR_PWR_CLK  = 7'h15;
  localparam logic [6:0] ADDR_SOFT_RST = 7'h17;
  localparam logic [6:0] ADDR_GPIO_DIR = 7'h1F;
  localparam logic [6:0] ADDR_GPIO_OUT = 7'h20;
  localparam logic [6:0] ADDR_GPIO_IN  = 7'h21;
  localparam int         CMD_RD_BIT    = 7;

  // Interface format fields
  localparam int        IF_CONT_BIT  = 0;
  localparam int        IF_STAT_BIT  = 1;
  localparam int        IF_CRC_BIT   = 2;
  localparam int        IF_RDY_BIT   = 3;
  localparam logic [7:0] IF_FMT_RST  = 8'h00;

  // Power and clock fields
  localparam int         PC_AIN_BIT  = 7;
  localparam int         PC_REF_BIT  = 6;
  localparam int         PC_PWR_LSB  = 4;
  localparam int         PC_DIV_LSB  = 0;
  localparam logic [7:0] PWR_CLK_RST = 8'h03;
  localparam logic [7:0] GPIO_RST    = 8'h00;

  // Frame lengths in bits
  localparam logic [5:0] LEN_RES  = 6'h18;
  localparam logic [5:0] LEN_BYTE = 6'h08;
  localparam logic [5:0] LEN_MAX  = 6'h3F;

  localparam logic [2:0] SYNC_PULSE_CYC = 3'h4;
  localparam logic [7:0] CRC_POLY       = 8'h07;
  localparam logic [7:0] CRC_INIT       = 8'h00;

  typedef enum logic [1:0] {
    PWR_FAST   = 2'h0,
    PWR_MEDIAN = 2'h1,
    PWR_LOW    = 2'h2,
    PWR_STBY   = 2'h3
  } acmsr_pwr_type;

  // Clock divide codes: /2, /4, /8, /16
  localparam logic [4:0] DIV_2  = 5'h02;
  localparam logic [4:0] DIV_4  = 5'h04;
  localparam logic [4:0] DIV_8  = 5'h08;
  localparam logic [4:0] DIV_16 = 5'h10;

  typedef struct packed {
    logic crc_err;
    logic flip_err;
    logic clk_missing;
    logic filt_settled;
    logic filt_sat;
    logic [2:0] rsvd;
  } acmsr_status_type;

  typedef struct packed {
    logic             valid;
    logic [RES_W-1:0] data;
  } acmsr_conv_type;

  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_CMD  = 5'h02,
    ST_WR   = 5'h04,
    ST_RD   = 5'h08,
    ST_STRM = 5'h10
  } acmsr_state_type;
endpackage : acmsr_pkg

/* File: hw/acmsr_top.sv */
`timescale 1ns/10ps
module acmsr_top (
  // Clock, reset, enable
  input  wire logic                           mclk,
  input  wire logic                           rstn,
  input  wire logic                           clk_en,
  // Method strap and reset pin
  input  wire logic                           ctrl_select_spi,
  input  wire logic                           hw_reset_n,
  // Serial port
  input  wire logic                           cs_n,
  input  wire logic                           sclk,
  input  wire logic                           sdi,
  output logic                                sdo,
  output logic                                sdo_oe,
  // Conversion core
  input  wire acmsr_pkg::acmsr_conv_type      conv,
  input  wire acmsr_pkg::acmsr_status_type    conv_status,
  // Ready and sync
  output logic                                result_ready_out,
  output logic                                sync_out,
  // Shared strap or GPIO pins
  input  wire logic [acmsr_pkg::GPIO_W-1:0]   general_io_pins_in,
  output logic [acmsr_pkg::GPIO_W-1:0]        general_io_pins_out,
  output logic [acmsr_pkg::GPIO_W-1:0]        general_io_pins_oe,
  // Core configuration
  output acmsr_pkg::acmsr_pwr_type            power_mode,
  output logic                                mod_clk_en,
  output logic                                ain_precharge_en,
  output logic                                ref_precharge_en,
  output logic [acmsr_pkg::GPIO_W-1:0]        strap_config
);
  import acmsr_pkg::*;

  // CRC-8 over the result word, MSB first
  function automatic logic [7:0] crc8(input logic [RES_W-1:0] d);
    logic [7:0] c;
    c = CRC_INIT;
    for (int i = RES_W - 1; i >= 0; i--) begin
      c = (c[7] ^ d[i]) ? ({c[6:0], 1'b0} ^ CRC_POLY) : {c[6:0], 1'b0};
    end
    return c;
  endfunction : crc8

  acmsr_state_type      state_q;
  logic                 spi_mode_q, method_done_q;
  logic                 sclk_q, cs_n_q;
  logic [5:0]           rcnt_q, ocnt_q, len_q;
  logic [CMD_W-1:0]     in_sr_q;
  logic [6:0]           addr_q;
  logic [FRAME_W-1:0]   frame_q;
  logic [RES_W-1:0]     result_q;
  acmsr_status_type     status_q;
  logic                 ready_q;
  logic [7:0]           if_fmt_q, pwr_clk_q, gpio_dir_q, gpio_out_q;
  logic [GPIO_W-1:0]    strap_q;
  logic                 rst_pin_q, por_q;
  logic [2:0]           sync_cnt_q;
  logic [4:0]           mod_cnt_q;
  logic                 sdo_q;

  logic                 rise, fall, cs_fall, soft_rst, cfg_rst, cont_rd;
  logic [CMD_W-1:0]     cmd_byte;
  logic                 cmd_done, wr_done;
  logic [4:0]           mod_div;

  // Edges of the host-driven serial clock and chip select
  assign rise     = clk_en & ~cs_n & sclk & ~sclk_q;
  assign fall     = clk_en & ~cs_n & ~sclk & sclk_q;
  assign cs_fall  = clk_en & ~cs_n & cs_n_q;
  assign cmd_byte = {in_sr_q[CMD_W-2:0], sdi};
  assign cmd_done = rise & (state_q == ST_CMD) & (rcnt_q == LEN_BYTE - 6'h01);
  assign wr_done  = rise & (state_q == ST_WR) & (rcnt_q == 2 * LEN_BYTE - 6'h01);
  assign cont_rd  = if_fmt_q[IF_CONT_BIT];
  // Write commits need register mode; straps rule in pin mode
  assign soft_rst = wr_done & spi_mode_q & (addr_q == ADDR_SOFT_RST);
  assign cfg_rst  = soft_rst | ~hw_reset_n;

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      sclk_q <= 1'b1;
      cs_n_q <= 1'b1;
    end else if (clk_en) begin
      sclk_q <= sclk;
      cs_n_q <= cs_n;
    end
  end

  // Method caught once after power-up, kept through pin and soft resets
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      spi_mode_q    <= 1'b0;
      method_done_q <= 1'b0;
    end else if (clk_en && !method_done_q) begin
      spi_mode_q    <= ctrl_select_spi;
      method_done_q <= 1'b1;
    end
  end

  // Frame state; chip select high always returns to idle
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      state_q <= ST_IDLE;
    end else if (clk_en) begin
      if (cs_n) begin
        state_q <= ST_IDLE;
      end else begin
        unique case (state_q)
          ST_IDLE: begin
            if (cs_fall) begin
              // Pin mode and continuous mode skip the address phase
              state_q <= (!spi_mode_q || cont_rd) ? ST_STRM : ST_CMD;
            end
          end
          ST_CMD: begin
            if (cmd_done) begin
              state_q <= cmd_byte[CMD_RD_BIT] ? ST_RD : ST_WR;
            end
          end
          ST_WR:   state_q <= ST_WR;
          ST_RD:   state_q <= ST_RD;
          ST_STRM: state_q <= ST_STRM;
          default: state_q <= ST_IDLE;
        endcase
      end
    end
  end

  // Input shifter, sampled on rising edges (mode 3)
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rcnt_q  <= 6'h00;
      in_sr_q <= 8'h00;
      addr_q  <= 7'h00;
    end else if (clk_en) begin
      if (cs_n) begin
        rcnt_q <= 6'h00;
      end else if (rise) begin
        in_sr_q <= cmd_byte;
        if (rcnt_q != LEN_MAX) begin
          rcnt_q <= rcnt_q + 6'h01;
        end
        if (cmd_done) begin
          addr_q <= cmd_byte[6:0];
        end
      end
    end
  end

  // Register writes; every write is dropped in pin mode
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      if_fmt_q   <= IF_FMT_RST;
      pwr_clk_q  <= PWR_CLK_RST;
      gpio_dir_q <= GPIO_RST;
      gpio_out_q <= GPIO_RST;
    end else if (clk_en) begin
      if (cfg_rst) begin
        if_fmt_q   <= IF_FMT_RST;
        pwr_clk_q  <= PWR_CLK_RST;
        gpio_dir_q <= GPIO_RST;
        gpio_out_q <= GPIO_RST;
      end else if (wr_done && spi_mode_q) begin
        unique case (addr_q)
          ADDR_IF_FMT:   if_fmt_q   <= cmd_byte;
          ADDR_PWR_CLK:  pwr_clk_q  <= cmd_byte;
          ADDR_GPIO_DIR: gpio_dir_q <= cmd_byte;
          ADDR_GPIO_OUT: gpio_out_q <= cmd_byte;
          default:       ;
        endcase
      end
    end
  end

  // Latest result and status; ready set wins over its clear
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      result_q <= '0;
      status_q <= '0;
      ready_q  <= 1'b0;
    end else if (clk_en) begin
      if (conv.valid) begin
        result_q <= conv.data;
        status_q <= conv_status;
        ready_q  <= 1'b1;
      end else if (cs_fall && (!spi_mode_q || cont_rd)) begin
        ready_q  <= 1'b0;
      end else if (cmd_done && cmd_byte[CMD_RD_BIT] && cmd_byte[6:0] == ADDR_RESULT) begin
        ready_q  <= 1'b0;
      end
    end
  end

  // Output frame: loaded at frame start in pin or continuous mode, or after a read address
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      frame_q <= '0;
      len_q   <= 6'h00;
      ocnt_q  <= 6'h00;
    end else if (clk_en) begin
      if (cs_fall && !spi_mode_q) begin
        frame_q <= {result_q, status_q, 8'h00};
        len_q   <= LEN_RES + LEN_BYTE;
        ocnt_q  <= 6'h00;
      end else if (cs_fall && cont_rd) begin
        unique case ({if_fmt_q[IF_STAT_BIT], if_fmt_q[IF_CRC_BIT]})
          2'h3:    frame_q <= {result_q, status_q, crc8(result_q)};
          2'h2:    frame_q <= {result_q, status_q, 8'h00};
          2'h1:    frame_q <= {result_q, crc8(result_q), 8'h00};
          default: frame_q <= {result_q, 16'h0000};
        endcase
        len_q  <= LEN_RES + (if_fmt_q[IF_STAT_BIT] ? LEN_BYTE : 6'h00)
                          + (if_fmt_q[IF_CRC_BIT] ? LEN_BYTE : 6'h00);
        ocnt_q <= 6'h00;
      end else if (cs_fall) begin
        // Stale count from an earlier frame would hide ready on data out
        ocnt_q <= 6'h00;
      end else if (cmd_done && cmd_byte[CMD_RD_BIT]) begin
        ocnt_q <= 6'h00;
        len_q  <= LEN_BYTE;
        unique case (cmd_byte[6:0])
          ADDR_RESULT: begin
            frame_q <= {result_q, 16'h0000};
            len_q   <= LEN_RES;
          end
          ADDR_IF_FMT:   frame_q <= {if_fmt_q, 32'h00000000};
          ADDR_PWR_CLK:  frame_q <= {pwr_clk_q, 32'h00000000};
          ADDR_GPIO_DIR: frame_q <= {gpio_dir_q, 32'h00000000};
          ADDR_GPIO_OUT: frame_q <= {gpio_out_q, 32'h00000000};
          ADDR_GPIO_IN:  frame_q <= {4'h0, general_io_pins_in, 32'h00000000};
          default:       frame_q <= '0;
        endcase
      end else if (fall && (state_q == ST_STRM || state_q == ST_RD)) begin
        frame_q <= {frame_q[FRAME_W-2:0], 1'b0};
        if (ocnt_q != LEN_MAX) begin
          ocnt_q <= ocnt_q + 6'h01;
        end
      end
    end
  end

  // Data out changes on falling edges, or shows ready before any data bit goes out; past the frame it repeats SDI
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      sdo_q <= 1'b1;
    end else if (clk_en) begin
      if (fall && (state_q == ST_STRM || state_q == ST_RD)) begin
        sdo_q <= (ocnt_q < len_q) ? frame_q[FRAME_W-1] : sdi;
      end else if (!cs_n && state_q != ST_RD && ocnt_q == 6'h00
                   && if_fmt_q[IF_RDY_BIT] && spi_mode_q) begin
        sdo_q <= ~ready_q;
      end
    end
  end

  assign sdo              = sdo_q;
  assign sdo_oe           = ~cs_n;
  assign result_ready_out = ready_q;

  // Strap capture; in pin mode, pin reset and power-up both raise a sync pulse
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      strap_q    <= '0;
      rst_pin_q  <= 1'b1;
      por_q      <= 1'b1;
      sync_cnt_q <= 3'h0;
    end else if (clk_en) begin
      rst_pin_q <= hw_reset_n;
      strap_q   <= general_io_pins_in;
      if (method_done_q) begin
        por_q <= 1'b0;
      end
      if (method_done_q && !spi_mode_q
          && (por_q || (hw_reset_n && !rst_pin_q) || strap_q != general_io_pins_in)) begin
        sync_cnt_q <= SYNC_PULSE_CYC;
      end else if (sync_cnt_q != 3'h0) begin
        sync_cnt_q <= sync_cnt_q - 3'h1;
      end
    end
  end

  assign sync_out = (sync_cnt_q != 3'h0);

  // Power mode and divider: from straps, or from separate register fields
  always_comb begin
    if (!spi_mode_q) begin
      unique case (strap_q)
        4'hC, 4'hD: power_mode = PWR_FAST;
        4'hE:       power_mode = PWR_LOW;
        4'hF:       power_mode = PWR_STBY;
        default:    power_mode = acmsr_pwr_type'(strap_q[3:2]);
      endcase
      unique case (power_mode)
        PWR_FAST:   mod_div = DIV_2;
        PWR_MEDIAN: mod_div = DIV_4;
        default:    mod_div = DIV_16;
      endcase
    end else begin
      power_mode = acmsr_pwr_type'(pwr_clk_q[PC_PWR_LSB +: 2]);
      unique case (pwr_clk_q[PC_DIV_LSB +: 2])
        2'h0:    mod_div = DIV_2;
        2'h1:    mod_div = DIV_4;
        2'h2:    mod_div = DIV_8;
        default: mod_div = DIV_16;
      endcase
    end
  end

  // Modulator clock enable; held off in standby
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      mod_cnt_q <= 5'h00;
    end else if (clk_en) begin
      mod_cnt_q <= (mod_cnt_q >= mod_div - 5'h01) ? 5'h00 : mod_cnt_q + 5'h01;
    end
  end

  assign mod_clk_en = (power_mode != PWR_STBY) && (mod_cnt_q == 5'h00);

  // Buffers forced on in pin mode; shared pins are inputs there
  assign ain_precharge_en    = !spi_mode_q | pwr_clk_q[PC_AIN_BIT];
  assign ref_precharge_en    = !spi_mode_q | pwr_clk_q[PC_REF_BIT];
  assign strap_config        = spi_mode_q ? '0 : strap_q;
  assign general_io_pins_out = gpio_out_q[GPIO_W-1:0];
  assign general_io_pins_oe  = spi_mode_q ? gpio_dir_q[GPIO_W-1:0] : '0;
endmodule : acmsr_top

/* File: sim/acmsr_checker_properties.sv */
`timescale 1ns/10ps
module acmsr_checker (
  // Clock and resets
  input wire logic                         mclk,
  input wire logic                         rstn,
  input wire logic                         hw_reset_n,
  // Method strap and serial port
  input wire logic                         ctrl_select_spi,
  input wire logic                         cs_n,
  input wire logic                         sclk,
  input wire logic                         sdo,
  input wire logic                         sdo_oe,
  // Core side
  input wire acmsr_pkg::acmsr_conv_type    conv,
  input wire logic                         result_ready_out,
  input wire logic                         sync_out,
  input wire logic                         ain_precharge_en,
  input wire logic                         ref_precharge_en,
  // Shared pins
  input wire logic [acmsr_pkg::GPIO_W-1:0] general_io_pins_in,
  input wire logic [acmsr_pkg::GPIO_W-1:0] general_io_pins_oe,
  input wire logic [acmsr_pkg::GPIO_W-1:0] strap_config
);
  import acmsr_pkg::*;
  logic first_q;
  logic spi_q;
  logic pin;
  // Own copy of the method, caught on the first edge like the design
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      first_q <= 1'b1;
      spi_q   <= 1'b0;
    end else if (first_q) begin
      first_q <= 1'b0;
      spi_q   <= ctrl_select_spi;
    end
  end
  assign pin = !first_q && !spi_q;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  chk_oe_tracks_cs: assert property (sdo_oe == !cs_n)
    else $error("data out enable does not follow chip select");
  chk_ready_on_result: assert property (conv.valid && hw_reset_n |=> result_ready_out)
    else $error("ready not raised after a new result");
  chk_pin_pins_input: assert property (pin |-> general_io_pins_oe == '0)
    else $error("shared pins driven in strap mode");
  chk_pin_precharge_on: assert property (pin |-> ain_precharge_en && ref_precharge_en)
    else $error("precharge buffers off in strap mode");
  chk_spi_no_straps: assert property (spi_q && !first_q |-> strap_config == '0 && !sync_out)
    else $error("strap or sync activity in register mode");
  chk_sync_four_cycles: assert property ($rose(sync_out) |-> sync_out [*4] ##1 !sync_out)
    else $error("sync pulse width wrong");
  chk_strap_resync: assert property (pin && $changed(general_io_pins_in) |-> ##[1:10] sync_out)
    else $error("no sync pulse after strap toggle");
  // Slack of two cycles after chip select falls for any frame preload
  chk_sdo_held_high: assert property (pin && !cs_n && !$past(cs_n) && !$past(cs_n, 2)
    && sclk && $past(sclk) |=> $stable(sdo) || cs_n)
    else $error("data out moved while serial clock high");
  cov_pin_frame: cover property (pin && $fell(cs_n));
  cov_spi_frame: cover property (spi_q && !first_q && $fell(cs_n));
  cov_resync: cover property (pin && $rose(sync_out));
endmodule : acmsr_checker

bind acmsr_top acmsr_checker acmsr_checker_inst (
  .mclk(mclk), .rstn(rstn), .hw_reset_n(hw_reset_n), .ctrl_select_spi(ctrl_select_spi),
  .cs_n(cs_n), .sclk(sclk), .sdo(sdo), .sdo_oe(sdo_oe), .conv(conv),
  .result_ready_out(result_ready_out), .sync_out(sync_out),
  .ain_precharge_en(ain_precharge_en), .ref_precharge_en(ref_precharge_en),
  .general_io_pins_in(general_io_pins_in), .general_io_pins_oe(general_io_pins_oe),
  .strap_config(strap_config)
);

/* File: sim/acmsr_host_model.sv */
`timescale 1ns/10ps
module acmsr_host_model (
  // Clock
  input wire logic mclk,
  // Serial master pins
  output logic     cs_n,
  output logic     sclk,
  output logic     sdi,
  input wire logic sdo
);
  // Four mclk per half, twice the slave's minimum
  localparam int HALF = 4;
  // Idle: deselected, clock parked high for mode 3
  initial begin
    cs_n = 1'b1;
    sclk = 1'b1;
    sdi  = 1'b1;
  end
  // Host always masters the clock; bits MSB first, sdo taken on rising sclk
  task automatic xfer(input int n, input logic [63:0] tx, output logic [63:0] rx);
    rx = '0;
    @(posedge mclk) #1 cs_n = 1'b0;
    repeat (HALF) @(posedge mclk);
    for (int i = n - 1; i >= 0; i--) begin
      #1 sclk = 1'b0;
      sdi = tx[i];
      repeat (HALF) @(posedge mclk);
      #1 rx = {rx[62:0], sdo};
      sclk = 1'b1;
      repeat (HALF) @(posedge mclk);
    end
    #1 cs_n = 1'b1;
    sdi = ~sdi; // Released line must not keep its last value
  endtask : xfer
endmodule : acmsr_host_model

/* File: sim/acmsr_tb_top.sv */
`timescale 1ns/10ps
module acmsr_tb_top;
  import acmsr_pkg::*;
  logic             mclk = 1'b0;
  logic             rstn, sel, hw_rst_n, cs_n, sclk, sdi, sdo, sdo_oe;
  logic             rdy, sync, mod_en, ain, refb;
  logic [3:0]       pins_in, pins_tb, pins_out, pins_oe, straps;
  acmsr_conv_type   conv;
  acmsr_status_type stat;
  acmsr_pwr_type    pwr;
  logic [63:0]      r;
  int               c;
  int               num_errors  = 0;
  int               check_count = 0;
  logic [3:0]       codes [3] = '{4'h4, 4'hE, 4'h0};
  int               divs [3]  = '{4, 16, 2};
  acmsr_pwr_type    pwrs [3]  = '{PWR_MEDIAN, PWR_LOW, PWR_FAST};

  // Shared pin level: design wins where it drives
  assign pins_in = (pins_oe & pins_out) | (~pins_oe & pins_tb);
  always #5 mclk = ~mclk;

  acmsr_top acmsr_top_inst (
    .mclk(mclk), .rstn(rstn), .clk_en(1'b1), .ctrl_select_spi(sel),
    .hw_reset_n(hw_rst_n), .cs_n(cs_n), .sclk(sclk), .sdi(sdi), .sdo(sdo),
    .sdo_oe(sdo_oe), .conv(conv), .conv_status(stat), .result_ready_out(rdy),
    .sync_out(sync), .general_io_pins_in(pins_in), .general_io_pins_out(pins_out),
    .general_io_pins_oe(pins_oe), .power_mode(pwr), .mod_clk_en(mod_en),
    .ain_precharge_en(ain), .ref_precharge_en(refb), .strap_config(straps)
  );
  acmsr_host_model acmsr_host_model_inst (
    .mclk(mclk), .cs_n(cs_n), .sclk(sclk), .sdi(sdi), .sdo(sdo)
  );

  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  task automatic end_of_test;
    $display("checks=%0d errors=%0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : end_of_test

  // Bounded poll for sync or modulator enable; running dry ends the run
  task automatic wait_hi(input bit on_mod, output int cyc);
    cyc = 0;
    do begin
      @(posedge mclk) #1 cyc++;
      if (cyc > 40) begin
        check(0, 1);
        end_of_test;
      end
    end while (!(on_mod ? mod_en : sync));
  endtask : wait_hi

  task automatic power_up(input logic spi);
    rstn = 1'b0;
    sel  = spi;
    repeat (10) @(posedge mclk);
    #1 rstn = 1'b1;
  endtask : power_up

  task automatic convert(input logic [23:0] d);
    conv = {1'b1, d};
    @(posedge mclk) #1 conv.valid = 1'b0;
  endtask : convert

  task automatic reg_wr(input logic [6:0] a, input logic [7:0] d);
    acmsr_host_model_inst.xfer(16, {48'h0, 1'b0, a, d}, r);
  endtask : reg_wr

  task automatic reg_rd(input logic [6:0] a, input int n);
    acmsr_host_model_inst.xfer(8 + n, {56'h0, 1'b1, a} << n, r);
    r = r & ((64'h1 << n) - 64'h1);
  endtask : reg_rd

  function automatic logic [7:0] crc8(input logic [23:0] d);
    logic [7:0] k;
    k = CRC_INIT;
    for (int i = 23; i >= 0; i--) begin
      k = {k[6:0], 1'b0} ^ ((k[7] ^ d[i]) ? CRC_POLY : 8'h00);
    end
    return k;
  endfunction : crc8

  initial begin
    hw_rst_n = 1'b1;
    conv     = '0;
    stat     = 8'hA5;
    pins_tb  = 4'h0;
    power_up(1'b0);
    // Wait for the sync pulse that power-up raises in pin mode
    wait_hi(0, c);
    check({ain, refb, pwr}, {2'b11, PWR_FAST});
    // Each frame also carries a register write that must be dropped
    for (int t = 0; t < 2; t++) begin
      convert(t ? 24'h7FFFFE : 24'h800001);
      check(rdy, 1'b1);
      acmsr_host_model_inst.xfer(40, {24'h0, 16'h1520, {24{t[0]}}}, r);
      check(r[39:0], {t ? 24'h7FFFFE : 24'h800001, 8'hA5, {8{t[0]}}});
      check(rdy, 1'b0);
    end
    check(pwr, PWR_FAST);
    $display("test pin_readout done");
    foreach (codes[i]) begin
      repeat (6) @(posedge mclk);
      #1 pins_tb = codes[i];
      wait_hi(0, c);
      repeat (3) wait_hi(1, c);
      check(c, divs[i]);
      check({pwr, straps}, {pwrs[i], codes[i]});
    end
    $display("test strap_modes done");
    repeat (6) @(posedge mclk);
    #1 hw_rst_n = 1'b0;
    repeat (3) @(posedge mclk);
    #1 hw_rst_n = 1'b1;
    wait_hi(0, c);
    $display("test hw_reset done");
    power_up(1'b1);
    repeat (3) @(posedge mclk);
    #1 sel = 1'b0;
    reg_wr(ADDR_SOFT_RST, 8'h01);
    reg_rd(ADDR_PWR_CLK, 8);
    check(r, PWR_CLK_RST);
    reg_wr(ADDR_PWR_CLK, 8'h01);
    repeat (3) wait_hi(1, c);
    check(c, 4);
    check({pwr, ain, straps, sync}, {PWR_FAST, 1'b0, 4'h0, 1'b0});
    // Cut command must not shift the next frame's bit count
    acmsr_host_model_inst.xfer(4, 64'h0, r);
    reg_rd(ADDR_PWR_CLK, 8);
    check(r, 8'h01);
    pins_tb = 4'hA;
    reg_wr(ADDR_GPIO_DIR, 8'h03);
    reg_wr(ADDR_GPIO_OUT, 8'h05);
    reg_rd(ADDR_GPIO_IN, 8);
    check({r[7:0], pins_oe}, 12'h093);
    convert(24'h123456);
    reg_rd(ADDR_RESULT, 24);
    check(r, 24'h123456);
    reg_rd(7'h7E, 8);
    check(r, 8'h00);
    // Ready on data out: low while a result waits, during the command
    reg_wr(ADDR_IF_FMT, 8'h08);
    acmsr_host_model_inst.xfer(32, {32'h0, 1'b1, ADDR_RESULT, 24'h0}, r);
    check(r[31:0], {8'hFF, 24'h123456});
    convert(24'h5A5A5A);
    acmsr_host_model_inst.xfer(32, {32'h0, 1'b1, ADDR_RESULT, 24'h0}, r);
    check(r[31:0], {8'h00, 24'h5A5A5A});
    $display("test reg_access done");
    reg_wr(ADDR_IF_FMT, 8'h07);
    convert(24'hC0FFEE);
    acmsr_host_model_inst.xfer(48, '1, r);
    check(r[47:0], {24'hC0FFEE, 8'hA5, crc8(24'hC0FFEE), 8'hFF});
    $display("test continuous done");
    end_of_test;
  end
endmodule : acmsr_tb_top
